/* File: sbcspi_sync.sv */
// shared constants of the serial register map and a two-stage synchroniser
`timescale 1ns/1ns
`default_nettype none

package sbcspi_pkg;
   localparam int FRAME_BITS = 16;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int ACC_BIT = 7;
   localparam int DATA_LSB = 8;
   localparam int CNT_W = 5;
   localparam logic [4:0] CNT_ADDR_DONE = 5'h07;
   localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
   localparam logic [4:0] CNT_LAST = 5'h0F;
   localparam logic [4:0] CNT_OVER = 5'h10;
   localparam logic [4:0] CNT_SAT = 5'h1F;
   // address ranges
   localparam logic [6:0] CTL_LAST = 7'h1E;
   localparam logic [6:0] PN_FIRST = 7'h20;
   localparam logic [6:0] PN_LAST = 7'h3F;
   localparam logic [6:0] STAT_FIRST = 7'h40;
   localparam logic [6:0] STAT_LAST = 7'h7E;
   // control registers
   localparam int NCTL = 20;
   localparam int IDX_MODE = 0;
   localparam int IDX_WD = 2;
   localparam int IDX_CAN = 3;
   localparam logic [6:0] CTL_ADDR [0:NCTL-1] = '{
      7'h01, 7'h02, 7'h03, 7'h04, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0C, 7'h0E,
      7'h0F, 7'h17, 7'h18, 7'h1C, 7'h1D, 7'h1A, 7'h1B, 7'h20, 7'h21, 7'h22};
   localparam logic [7:0] CTL_WMASK [0:NCTL-1] = '{
      8'hFF, 8'h41, 8'hF7, 8'h07, 8'h44, 8'hA1, 8'hC3, 8'h10, 8'h7F, 8'hB8,
      8'hFD, 8'h07, 8'hFF, 8'h03, 8'h07, 8'hFF, 8'hFF, 8'hF1, 8'hFF, 8'h3F};
   // bits the device itself may change
   localparam logic [7:0] CTL_HWMASK [0:NCTL-1] = '{
      8'hD8, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] STOP_MODE_WMASK = 8'hC0;
   // fields of the mode/supply and transceiver registers
   localparam int MODE_HI = 7;
   localparam int MODE_LO = 6;
   localparam int FO_BIT = 5;
   localparam int AUX_HI = 4;
   localparam int AUX_LO = 3;
   localparam int CAN_HI = 2;
   localparam int CAN_LO = 0;
   localparam logic [2:0] CAN_OFF = 3'h0;
   localparam logic [2:0] CAN_WAKE = 3'h1;
   localparam logic [1:0] AUX_OFF = 2'h0;
   typedef enum logic [1:0] {
      SBCSPI_NORMAL = 2'h0,
      SBCSPI_SLEEP = 2'h1,
      SBCSPI_STOP = 2'h2,
      SBCSPI_RESTART = 2'h3
   } sbcspi_mode_t;
   // status registers
   localparam int NSTICKY = 8;
   localparam int NLIVE = 6;
   localparam logic [6:0] LIVE_FIRST = 7'h48;
   localparam logic [6:0] FAMILY_ADDR = 7'h7E;
endpackage

module sbcspi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clock, // destination clock
   input wire logic rst, // synchronous reset
   input wire logic [W-1:0] din, // foreign-domain levels
   output logic [W-1:0] dout // synchronised levels
);
   logic [W-1:0] meta_q;
   logic [W-1:0] hold_q;

   // first stage feeds only the second
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_q <= INIT;
         hold_q <= INIT;
      end else begin
         meta_q <= din;
         hold_q <= meta_q;
      end
   end

   assign dout = hold_q;
endmodule
`default_nettype wire

/* File: sbcspi_regmap.sv */
// serial-port register map: frame shifter, decode, control and status bank
`timescale 1ns/1ns
`default_nettype none

// Function
// - command: address 6..0, access 7, data 15..8
// - addresses 00h..1Eh are read/write control
// - addresses 20h..3Fh are partial-network control
// - access 0 reads only, access 1 writes
// - reply shows old value, new on next
// - writes commit at chip-select rising edge
// - addresses 40h..7Eh are status registers
// - access 1 clears status after returning it
// - live and identifier registers ignore clears
// - drivers enable despite set failure flags
// - mode field follows the mode entered
// - low power keeps diagnosis, fail output
// - stop mode leaves transceiver bits unchanged
// - sleep forces an enabled transceiver to wake capable
// - aux regulator writable in normal only
// - aux failure switches regulator off silently
// - restart clears aux regulator, keeps fail
// - restart sets transceiver off or wake capable
// - device-modified bits carry own access mask
// - restart mode ignores serial writes and clears, still answers reads
module sbcspi_regmap #(
   parameter logic [7:0] FAMILY_ID = 8'h5A // arbitrary identifier
) (
   input wire logic clock, // system clock, 100 MHz
   input wire logic rst, // reset, active high; asynchronous for the frame toggle
   input wire logic spiClk, // serial clock from the master
   input wire logic csnN, // chip select, active low
   input wire logic mosi, // serial data in
   output logic sdoOut, // serial data out
   output logic sdoEn, // serial data out enable
   input wire logic [1:0] actualMode, // mode actually entered
   input wire logic auxRegFail, // aux regulator failure pulse
   input wire logic failTrigger, // fail output trigger pulse
   input wire logic [63:0] statusSet, // sticky status set pulses
   input wire logic [47:0] liveStatus, // live status bytes
   output logic [1:0] modeRequest, // last written mode
   output logic [2:0] canMode, // transceiver control
   output logic [1:0] auxRegEnable, // aux regulator control
   output logic failOutput // fail output level
);
   // link domain
   logic [sbcspi_pkg::CNT_W-1:0] bitCnt_q;
   logic [sbcspi_pkg::FRAME_BITS-1:0] shift_q;
   logic frameTog_q;
   logic [7:0] rdByte_q;
   logic sdo_q;
   logic [6:0] linkAddr;
   logic [7:0] linkRdData;
   // system domain
   logic [7:0] ctl_q [0:sbcspi_pkg::NCTL-1];
   logic [7:0] ctlNext [0:sbcspi_pkg::NCTL-1];
   logic [7:0] wrMask [0:sbcspi_pkg::NCTL-1];
   logic [7:0] stat_q [0:sbcspi_pkg::NSTICKY-1];
   logic [7:0] pend_q [0:sbcspi_pkg::NSTICKY-1];
   logic [7:0] live_q [0:sbcspi_pkg::NLIVE-1];
   logic [1:0] syncOut;
   logic csnSync;
   logic togSync;
   logic csnPrev_q;
   logic togSeen_q;
   logic commitPulse;
   logic commitOk;
   logic frameActive;
   logic [6:0] cmdAddr;
   logic cmdWrite;
   logic [7:0] cmdData;
   logic [1:0] modeSeen_q;
   logic modeChange;
   logic hwMove;
   logic auxFailPend_q;
   logic auxFailApply;
   logic failLatch_q;
   logic failClear;
   logic [1:0] modeReq_q;

   // ---------------- link domain ----------------
   // counter restarts with every frame; clock stops outside frames
   always_ff @(posedge spiClk or posedge csnN) begin
      if (csnN) begin
         bitCnt_q <= '0;
      end else if (bitCnt_q != sbcspi_pkg::CNT_SAT) begin
         bitCnt_q <= bitCnt_q + 5'h01;
      end
   end

   // first bit sent is bit 0
   always_ff @(posedge spiClk) begin
      shift_q <= {mosi, shift_q[sbcspi_pkg::FRAME_BITS-1:1]};
   end

   // toggles at bit 16 and back at bit 17: only exact frames count
   always_ff @(posedge spiClk or posedge rst) begin
      if (rst) begin
         frameTog_q <= 1'b0;
      end else if (bitCnt_q == sbcspi_pkg::CNT_LAST ||
                   bitCnt_q == sbcspi_pkg::CNT_OVER) begin
         frameTog_q <= ~frameTog_q;
      end
   end

   assign linkAddr = shift_q[sbcspi_pkg::FRAME_BITS-1:9];

   // the system registers read here only move while chip select is high, so they are
   // stable whenever this mux is sampled in the link domain
   always_comb begin
      linkRdData = 8'h00;
      if (linkAddr <= sbcspi_pkg::PN_LAST) begin
         for (int i = 0; i < sbcspi_pkg::NCTL; i++) begin
            if (linkAddr == sbcspi_pkg::CTL_ADDR[i]) begin
               linkRdData = ctl_q[i];
            end
         end
      end else if (linkAddr == sbcspi_pkg::FAMILY_ADDR) begin
         linkRdData = FAMILY_ID;
      end else begin
         for (int i = 0; i < sbcspi_pkg::NSTICKY; i++) begin
            if (linkAddr == sbcspi_pkg::STAT_FIRST + 7'(i)) begin
               linkRdData = stat_q[i];
            end
         end
         for (int i = 0; i < sbcspi_pkg::NLIVE; i++) begin
            if (linkAddr == sbcspi_pkg::LIVE_FIRST + 7'(i)) begin
               linkRdData = live_q[i];
            end
         end
      end
   end

   // reply byte taken before the write commits
   always_ff @(posedge spiClk) begin
      if (bitCnt_q == sbcspi_pkg::CNT_ADDR_DONE) begin
         rdByte_q <= linkRdData;
      end
   end

   always_ff @(negedge spiClk or posedge csnN) begin
      if (csnN) begin
         sdo_q <= 1'b0;
      end else if (bitCnt_q >= sbcspi_pkg::CNT_DATA_FIRST &&
                   bitCnt_q <= sbcspi_pkg::CNT_LAST) begin
         sdo_q <= rdByte_q[bitCnt_q[2:0]];
      end else begin
         sdo_q <= 1'b0;
      end
   end

   assign sdoOut = sdo_q;
   assign sdoEn = ~csnN;

   // ---------------- crossing ----------------
   sbcspi_sync #(
      .W(2),
      .INIT(2'h1)
   ) uSync (
      .clock(clock),
      .rst(rst),
      .din({frameTog_q, csnN}),
      .dout(syncOut)
   );

   assign csnSync = syncOut[0];
   assign togSync = syncOut[1];
   assign frameActive = ~csnSync;

   always_ff @(posedge clock) begin
      if (rst) begin
         csnPrev_q <= 1'b1;
         togSeen_q <= 1'b0;
      end else begin
         csnPrev_q <= csnSync;
         if (commitPulse) begin
            togSeen_q <= togSync;
         end
      end
   end

   // frame word is still because the serial clock has stopped
   assign commitPulse = csnSync & ~csnPrev_q & (togSync != togSeen_q);
   assign commitOk = commitPulse &&
                     modeSeen_q != sbcspi_pkg::SBCSPI_RESTART;
   assign cmdAddr = shift_q[sbcspi_pkg::ADDR_W-1:0];
   assign cmdWrite = shift_q[sbcspi_pkg::ACC_BIT];
   assign cmdData = shift_q[sbcspi_pkg::FRAME_BITS-1:sbcspi_pkg::DATA_LSB];

   // ---------------- mode tracking ----------------
   assign modeChange = actualMode != modeSeen_q;
   assign hwMove = modeChange && !frameActive;
   assign auxFailApply = (auxFailPend_q | auxRegFail) && !frameActive;

   always_ff @(posedge clock) begin
      if (rst) begin
         modeSeen_q <= sbcspi_pkg::SBCSPI_NORMAL;
      end else if (hwMove) begin
         modeSeen_q <= actualMode;
      end
   end

   // failure seen mid-frame waits until the frame ends
   always_ff @(posedge clock) begin
      if (rst) begin
         auxFailPend_q <= 1'b0;
      end else begin
         auxFailPend_q <= (auxFailPend_q | auxRegFail) && frameActive;
      end
   end

   // ---------------- control registers ----------------
   always_comb begin
      for (int i = 0; i < sbcspi_pkg::NCTL; i++) begin
         wrMask[i] = 8'h00;
         if (commitOk && cmdWrite && cmdAddr == sbcspi_pkg::CTL_ADDR[i]) begin
            case (modeSeen_q)
               sbcspi_pkg::SBCSPI_NORMAL: begin
                  wrMask[i] = sbcspi_pkg::CTL_WMASK[i];
               end
               sbcspi_pkg::SBCSPI_STOP: begin
                  if (i == sbcspi_pkg::IDX_MODE) begin
                     wrMask[i] = sbcspi_pkg::STOP_MODE_WMASK;
                  end else if (i == sbcspi_pkg::IDX_WD) begin
                     wrMask[i] = sbcspi_pkg::CTL_WMASK[i];
                  end
               end
               default: begin
                  wrMask[i] = 8'h00;
               end
            endcase
         end
      end
   end

   always_comb begin
      logic [7:0] base;
      logic [7:0] hwv;
      base = 8'h00;
      hwv = 8'h00;
      for (int i = 0; i < sbcspi_pkg::NCTL; i++) begin
         base = (ctl_q[i] & ~wrMask[i]) | (cmdData & wrMask[i]);
         hwv = base;
         if (i == sbcspi_pkg::IDX_MODE) begin
            if (hwMove) begin
               hwv[sbcspi_pkg::MODE_HI:sbcspi_pkg::MODE_LO] =
                  actualMode;
               if (actualMode == sbcspi_pkg::SBCSPI_RESTART) begin
                  hwv[sbcspi_pkg::AUX_HI:sbcspi_pkg::AUX_LO] =
                     sbcspi_pkg::AUX_OFF;
               end
            end
            if (auxFailApply) begin
               hwv[sbcspi_pkg::AUX_HI:sbcspi_pkg::AUX_LO] =
                  sbcspi_pkg::AUX_OFF;
            end
         end
         if (i == sbcspi_pkg::IDX_CAN && hwMove) begin
            case (actualMode)
               sbcspi_pkg::SBCSPI_SLEEP,
               sbcspi_pkg::SBCSPI_RESTART: begin
                  if (base[sbcspi_pkg::CAN_HI:sbcspi_pkg::CAN_LO] !=
                      sbcspi_pkg::CAN_OFF) begin
                     hwv[sbcspi_pkg::CAN_HI:sbcspi_pkg::CAN_LO] =
                        sbcspi_pkg::CAN_WAKE;
                  end
               end
               default: begin
                  hwv = base;
               end
            endcase
         end
         // device may only touch its own bits
         ctlNext[i] = (base & ~sbcspi_pkg::CTL_HWMASK[i]) |
                      (hwv & sbcspi_pkg::CTL_HWMASK[i]);
      end
   end

   always_ff @(posedge clock) begin
      for (int i = 0; i < sbcspi_pkg::NCTL; i++) begin
         if (rst) begin
            ctl_q[i] <= sbcspi_pkg::CTL_RESET;
         end else begin
            ctl_q[i] <= ctlNext[i];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         modeReq_q <= sbcspi_pkg::SBCSPI_NORMAL;
      end else if (wrMask[sbcspi_pkg::IDX_MODE] != 8'h00) begin
         modeReq_q <= cmdData[sbcspi_pkg::MODE_HI:sbcspi_pkg::MODE_LO];
      end
   end

   // ---------------- fail output ----------------
   assign failClear = wrMask[sbcspi_pkg::IDX_MODE] != 8'h00 &&
                      !cmdData[sbcspi_pkg::FO_BIT];

   // mode changes never release a triggered fail output; trigger beats clear
   always_ff @(posedge clock) begin
      if (rst) begin
         failLatch_q <= 1'b0;
      end else if (failTrigger) begin
         failLatch_q <= 1'b1;
      end else if (failClear) begin
         failLatch_q <= 1'b0;
      end
   end

   // ---------------- status registers ----------------
   // events during a frame are parked so the reply mux stays still
   always_ff @(posedge clock) begin
      for (int i = 0; i < sbcspi_pkg::NSTICKY; i++) begin
         if (rst) begin
            stat_q[i] <= 8'h00;
            pend_q[i] <= 8'h00;
         end else if (frameActive) begin
            pend_q[i] <= pend_q[i] | statusSet[i*8 +: 8];
         end else begin
            pend_q[i] <= 8'h00;
            if (commitOk && cmdWrite &&
                cmdAddr == sbcspi_pkg::STAT_FIRST + 7'(i)) begin
               stat_q[i] <= pend_q[i] | statusSet[i*8 +: 8];
            end else begin
               stat_q[i] <= stat_q[i] | pend_q[i] | statusSet[i*8 +: 8];
            end
         end
      end
   end

   // live bytes have no clear path at all
   always_ff @(posedge clock) begin
      for (int i = 0; i < sbcspi_pkg::NLIVE; i++) begin
         if (rst) begin
            live_q[i] <= 8'h00;
         end else if (!frameActive) begin
            live_q[i] <= liveStatus[i*8 +: 8];
         end
      end
   end

   // ---------------- outputs ----------------
   // drivers follow configuration alone, never the failure flags
   assign canMode = ctl_q[sbcspi_pkg::IDX_CAN][sbcspi_pkg::CAN_HI:
                                               sbcspi_pkg::CAN_LO];
   assign auxRegEnable = ctl_q[sbcspi_pkg::IDX_MODE][sbcspi_pkg::AUX_HI:
                                                     sbcspi_pkg::AUX_LO];
   assign failOutput = failLatch_q |
                       ctl_q[sbcspi_pkg::IDX_MODE][sbcspi_pkg::FO_BIT];
   assign modeRequest = modeReq_q;

   // ---------------- checks ----------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence sModeMoved;
      hwMove;
   endsequence

   sequence sCanWrite;
      commitOk && cmdWrite &&
      cmdAddr == sbcspi_pkg::CTL_ADDR[sbcspi_pkg::IDX_CAN] &&
      modeSeen_q == sbcspi_pkg::SBCSPI_NORMAL && !hwMove;
   endsequence

   AST_CAN_WRITE: assert property (
      sCanWrite |=> canMode == $past(cmdData[2:0]))
      else $error("transceiver write not stored");

   AST_READ_NO_WRITE: assert property (
      commitPulse && !cmdWrite && !hwMove |=> $stable(canMode))
      else $error("read-only access changed a register");

   AST_FRAME_HOLD: assert property (
      frameActive |=> $stable(canMode) && $stable(auxRegEnable))
      else $error("control changed while frame open");

   AST_STAT_CLEAR: assert property (
      commitOk && cmdWrite && cmdAddr == sbcspi_pkg::STAT_FIRST &&
      pend_q[0] == 8'h00 && statusSet[7:0] == 8'h00
      |=> stat_q[0] == 8'h00)
      else $error("status byte not cleared");

   AST_MODE_TRACK: assert property (
      sModeMoved |=> ctl_q[sbcspi_pkg::IDX_MODE][7:6] == $past(actualMode))
      else $error("mode field does not follow mode");

   AST_SLEEP_CAN: assert property (
      sModeMoved ##0 actualMode == sbcspi_pkg::SBCSPI_SLEEP &&
      canMode != sbcspi_pkg::CAN_OFF && !commitOk
      |=> canMode == sbcspi_pkg::CAN_WAKE)
      else $error("sleep left transceiver active");

   AST_STOP_CAN: assert property (
      sModeMoved ##0 actualMode == sbcspi_pkg::SBCSPI_STOP && !commitOk
      |=> $stable(canMode))
      else $error("stop modified transceiver bits");

   AST_RESTART_AUX: assert property (
      sModeMoved ##0 actualMode == sbcspi_pkg::SBCSPI_RESTART
      |=> auxRegEnable == sbcspi_pkg::AUX_OFF ##1 !commitOk[*2])
      else $error("restart kept aux regulator on");

   AST_RESTART_IGNORE: assert property (
      commitPulse && modeSeen_q == sbcspi_pkg::SBCSPI_RESTART && !hwMove
      |=> $stable(canMode) && $stable(modeRequest))
      else $error("frame interpreted in restart");

   AST_FAIL_HOLD: assert property (
      failTrigger |=> failOutput ##1 (failOutput || $past(failClear)))
      else $error("fail output dropped");
endmodule
`default_nettype wire

/* File: sbcspi_master_model.sv */
// behavioural serial master that frames commands into the register map
`timescale 1ns/1ns
`default_nettype none
module sbcspi_master_model (
   input wire logic clock, // system clock, paces the gap between frames
   input wire logic start, // begin one frame
   input wire logic [15:0] cmd, // command word, bit 0 first
   input wire logic [5:0] nBits, // clocks in this frame
   input wire logic sdoOut, // serial data from the device
   input wire logic sdoEn, // device output enable
   output logic spiClk, // serial clock, still outside frames
   output logic csnN, // chip select, active low
   output logic mosi, // serial data to the device
   output logic busy, // frame or gap in progress
   output logic [7:0] reply // data byte returned
);
   int k;
   initial begin
      spiClk = 1'b0;
      mosi = 1'b0;
      busy = 1'b0;
      reply = 8'h00;
      // late rise so the link counter surely sees a clearing edge
      #1 csnN = 1'b1;
   end
   always begin
      @(posedge clock iff start);
      busy = 1'b1;
      #3 csnN = 1'b0;
      #6;
      for (k = 0; k < nBits; k++) begin
         mosi = cmd[k % 16];
         #6;
         // a disabled output must not pass for data
         if (k >= 8 && k < 16) reply[k-8] = sdoEn ? sdoOut : 1'bx;
         spiClk = 1'b1;
         #6 spiClk = 1'b0;
      end
      #6 csnN = 1'b1;
      mosi = ~mosi;
      // gap covers the commit after chip select rises
      repeat (8) @(posedge clock);
      #1 busy = 1'b0;
   end
endmodule
`default_nettype wire

/* File: test_sbcspi_regmap.sv */
// self-checking bench for the serial register map
`timescale 1ns/1ns
`default_nettype none
module test_sbcspi_regmap;
   logic clock = 1'b0;
   logic rst;
   logic [1:0] actualMode = 2'h0;
   logic auxRegFail = 1'b0;
   logic failTrigger = 1'b0;
   logic [63:0] statusSet = 64'h0;
   logic [47:0] liveStatus = 48'h00000000003C;
   logic start = 1'b0;
   logic [15:0] cmd = 16'h0000;
   logic [5:0] nBits = 6'h10;
   wire logic spiClk, csnN, mosi, sdoOut, sdoEn, busy;
   wire logic [7:0] reply;
   wire logic [1:0] modeRequest, auxRegEnable;
   wire logic [2:0] canMode;
   wire logic failOutput;
   logic [7:0] r;
   int fails = 0;
   int comparisons = 0;
   int i;

   always #5 clock = ~clock;

   sbcspi_regmap u_sbcspi_regmap (.clock(clock), .rst(rst),
      .spiClk(spiClk), .csnN(csnN), .mosi(mosi), .sdoOut(sdoOut),
      .sdoEn(sdoEn), .actualMode(actualMode), .auxRegFail(auxRegFail),
      .failTrigger(failTrigger), .statusSet(statusSet),
      .liveStatus(liveStatus), .modeRequest(modeRequest),
      .canMode(canMode), .auxRegEnable(auxRegEnable),
      .failOutput(failOutput));
   sbcspi_master_model u_sbcspi_master_model (.clock(clock),
      .start(start), .cmd(cmd), .nBits(nBits), .sdoOut(sdoOut),
      .sdoEn(sdoEn), .spiClk(spiClk), .csnN(csnN), .mosi(mosi),
      .busy(busy), .reply(reply));

   task end_of_test;
      if (fails == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task xfer(input logic [6:0] a, input logic acc, input logic [7:0] d,
         input logic [5:0] n);
      int k;
      @(posedge clock);
      cmd <= {d, acc, a};
      nBits <= n;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      k = 0;
      do begin
         @(negedge clock);
         k++;
      end while (busy !== 1'b0 && k < 200);
      if (k >= 200) begin
         fails++;
         end_of_test();
      end
      r = reply;
   endtask

   task wr(input logic [6:0] a, input logic [7:0] d);
      xfer(a, 1'b1, d, 6'h10);
   endtask

   task rd(input logic [6:0] a, input logic acc, input logic [7:0] exp);
      xfer(a, acc, 8'h00, 6'h10);
      check(r, exp);
   endtask

   // mode change, then a few edges for the deferred update to land
   task setMode(input logic [1:0] m);
      @(posedge clock);
      actualMode <= m;
      repeat (4) @(posedge clock);
   endtask

   task pulse(input int which);
      @(posedge clock);
      if (which == 0) failTrigger <= 1'b1;
      else auxRegFail <= 1'b1;
      @(posedge clock);
      failTrigger <= 1'b0;
      auxRegFail <= 1'b0;
      @(negedge clock);
   endtask

   initial begin
      // edge at time zero clears the link-side frame toggle
      rst <= 1'b1;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      repeat (3) @(posedge clock);
      check({failOutput, auxRegEnable, canMode, modeRequest}, 8'h00);
      // every mapped control register: masks, old value in reply
      for (i = 0; i < sbcspi_pkg::NCTL; i++) begin
         wr(sbcspi_pkg::CTL_ADDR[i], 8'hFF);
         check(r, 8'h00);
         wr(sbcspi_pkg::CTL_ADDR[i], 8'h00);
         check(r, sbcspi_pkg::CTL_WMASK[i]);
      end
      rd(7'h01, 1'b0, 8'h00);
      wr(7'h05, 8'hFF);
      rd(7'h05, 1'b0, 8'h00);
      rd(7'h3F, 1'b1, 8'h00);
      wr(7'h04, 8'hFF);
      check({5'h00, canMode}, 8'h07);
      xfer(7'h04, 1'b0, 8'h00, 6'h10);
      check({5'h00, canMode}, 8'h07);
      xfer(7'h04, 1'b1, 8'h00, 6'h0F);
      check({5'h00, canMode}, 8'h07);
      xfer(7'h04, 1'b1, 8'h00, 6'h11);
      check({5'h00, canMode}, 8'h07);
      // status: sticky read, read and clear, live and identifier
      @(posedge clock);
      statusSet <= 64'h00000000000FA5C3;
      @(posedge clock);
      statusSet <= 64'h0;
      rd(7'h41, 1'b0, 8'hA5);
      rd(7'h41, 1'b1, 8'hA5);
      rd(7'h41, 1'b0, 8'h00);
      rd(7'h40, 1'b1, 8'hC3);
      rd(7'h40, 1'b0, 8'h00);
      rd(7'h48, 1'b1, 8'h3C);
      rd(7'h48, 1'b0, 8'h3C);
      rd(7'h7E, 1'b1, 8'h5A);
      rd(7'h7E, 1'b0, 8'h5A);
      rd(7'h42, 1'b0, 8'h0F);
      wr(7'h04, 8'h07);
      check({5'h00, canMode}, 8'h07);
      // mode transitions
      setMode(sbcspi_pkg::SBCSPI_STOP);
      rd(7'h01, 1'b0, 8'h80);
      check({5'h00, canMode}, 8'h07);
      pulse(0);
      setMode(sbcspi_pkg::SBCSPI_SLEEP);
      check({5'h00, canMode}, 8'h01);
      check({7'h00, failOutput}, 8'h01);
      setMode(sbcspi_pkg::SBCSPI_NORMAL);
      rd(7'h01, 1'b0, 8'h00);
      wr(7'h01, 8'h18);
      check({6'h00, auxRegEnable}, 8'h03);
      check({7'h00, failOutput}, 8'h00);
      setMode(sbcspi_pkg::SBCSPI_STOP);
      check({6'h00, auxRegEnable}, 8'h03);
      // in the mode register, stop lets only the mode field through
      wr(7'h01, 8'h40);
      check({6'h00, auxRegEnable}, 8'h03);
      check({6'h00, modeRequest}, 8'h01);
      setMode(sbcspi_pkg::SBCSPI_NORMAL);
      pulse(1);
      repeat (4) @(posedge clock);
      check({6'h00, auxRegEnable}, 8'h00);
      pulse(0);
      wr(7'h01, 8'h38);
      wr(7'h04, 8'h07);
      setMode(sbcspi_pkg::SBCSPI_RESTART);
      check({6'h00, auxRegEnable}, 8'h00);
      check({7'h00, failOutput}, 8'h01);
      check({5'h00, canMode}, 8'h01);
      wr(7'h04, 8'h07);
      check({5'h00, canMode}, 8'h01);
      setMode(sbcspi_pkg::SBCSPI_NORMAL);
      end_of_test();
   end
endmodule
`default_nettype wire
